// file: hdl/display_lvds_serdes_7to1.sv
`timescale 1ns/1ns
`include "lvds_link_defs.svh"

// Function
// - transmitter takes 21 parallel bits per pixel
// - capture inputs on pixel clock falling edge
// - seven serial slots per lane per cycle
// - lane 2 sends inputs 20 down to 14
// - lane 1 sends inputs 13 down to 7
// - three data lanes plus one clock lane
// - slots referenced to link clock falling edge
// - sleep floats all transmitter outputs
// - receiver rebuilds 21 bits from lanes
// - recovered pixel clock falls on valid data
// - receiver sleep freezes parallel outputs
// - transmitter sleeps within 100 ns

module display_lvds_serdes_7to1
	import lvds_link_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int WORD_W = `PIX_WORD_W,
	parameter int LANES  = `LINK_LANES,
	parameter int SLOTS  = `LINK_SLOTS
) (
	input  wire logic              i_mclk,
	input  wire logic              i_sys_rst,
	input  wire logic              i_ce,
	input  wire logic              i_link_clk,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	input  wire logic [WORD_W-1:0] i_tx_parallel_in,
	input  wire logic              i_pixel_clk_in,
	input  wire logic              i_tx_sleep_n,
	output logic      [LANES-1:0]  o_tx_serial_lane,
	output logic      [LANES-1:0]  o_tx_serial_lane_oe,
	output logic                   o_link_clock_out,
	output logic                   o_link_clock_out_oe,
	input  wire logic [LANES-1:0]  i_rx_serial_lane,
	input  wire logic              i_link_clock_in,
	input  wire logic              i_rx_sleep_n,
	output logic      [WORD_W-1:0] o_rx_parallel_out,
	output logic                   o_pixel_clk_out
);

	localparam int PIN_W         = WORD_W + LANES + 4;
	localparam int TX_SLEEP_CYC  = `TX_SLEEP_MAX_NS / `LINK_PERIOD_NS;
	localparam int TX_SLEEP_WAIT = TX_SLEEP_CYC - 4;
	localparam int HW            = $clog2(`RX_PIXCLK_HIGH_CYC);
	localparam logic [HW-1:0] HIGH_LAST = HW'(`RX_PIXCLK_HIGH_CYC - 1);

	// ================================================================
	// register bus, system clock
	ctrl_type   ctrl_reg;
	status_type stat_m_reg;
	status_type stat_reg;
	logic       apb_access;
	logic       hit_ctrl;
	logic       hit_status;

	assign apb_access = i_psel & i_penable;
	assign hit_ctrl   = (i_paddr == ADDR_W'(`CTRL_OFS));
	assign hit_status = (i_paddr == ADDR_W'(`STATUS_OFS));
	// zero wait states; a frozen block holds the master off
	assign o_pready   = i_ce;
	assign o_pslverr  = apb_access & ~(hit_ctrl | hit_status);

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			ctrl_reg <= ctrl_type'(`CTRL_RST_VAL);
		end else if (i_ce && apb_access && i_pwrite && hit_ctrl) begin
			ctrl_reg.tx_en <= i_pwdata[`CTRL_TX_EN_BIT];
			ctrl_reg.rx_en <= i_pwdata[`CTRL_RX_EN_BIT];
		end
	end

	// read data is staged in the setup phase so it comes from a flop
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_prdata <= '0;
		end else if (i_ce && i_psel && !i_penable) begin
			o_prdata <= '0;
			if (hit_ctrl) begin
				o_prdata[`CTRL_TX_EN_BIT] <= ctrl_reg.tx_en;
				o_prdata[`CTRL_RX_EN_BIT] <= ctrl_reg.rx_en;
			end else if (hit_status) begin
				o_prdata[`STATUS_TX_ACT_BIT]   <= stat_reg.tx_active;
				o_prdata[`STATUS_RX_LOCK_BIT]  <= stat_reg.rx_locked;
				o_prdata[`STATUS_RX_AWAKE_BIT] <= stat_reg.rx_awake;
			end
		end
	end

	// ================================================================
	// status levels into the system clock
	status_type stat_link_reg;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			stat_m_reg <= '0;
			stat_reg   <= '0;
		end else if (i_ce) begin
			stat_m_reg <= stat_link_reg;
			stat_reg   <= stat_m_reg;
		end
	end

	// ================================================================
	// reset, enable and control into the link clock
	logic     lrst_m_reg;
	logic     lrst_reg;
	logic     ce_m_reg;
	logic     ce_l_reg;
	ctrl_type ctrl_m_reg;
	ctrl_type ctrl_l_reg;

	always_ff @(posedge i_link_clk) begin
		lrst_m_reg <= i_sys_rst;
		lrst_reg   <= lrst_m_reg;
		ce_m_reg   <= i_ce;
		ce_l_reg   <= ce_m_reg;
	end

	always_ff @(posedge i_link_clk) begin
		if (lrst_reg) begin
			ctrl_m_reg <= ctrl_type'(`CTRL_RST_VAL);
			ctrl_l_reg <= ctrl_type'(`CTRL_RST_VAL);
		end else if (ce_l_reg) begin
			ctrl_m_reg <= ctrl_reg;
			ctrl_l_reg <= ctrl_m_reg;
		end
	end

	// ================================================================
	// pin synchronisers: three flops; except for the received data and clock lanes, accept once stages two and three agree
	logic [PIN_W-1:0]  pin_raw;
	logic [PIN_W-1:0]  pin_filt;
	logic              tx_sleep_n_f;
	logic              pix_f;
	logic [WORD_W-1:0] tx_data_f;
	logic              rx_sleep_n_f;
	logic              clk_lane_f;
	logic [LANES-1:0]  rx_lanes_f;

	assign pin_raw = {i_tx_sleep_n, i_pixel_clk_in, i_tx_parallel_in,
	                  i_rx_sleep_n, i_link_clock_in, i_rx_serial_lane};

	for (genvar gi = 0; gi < PIN_W; gi++) begin : g_pin
		logic s1_reg;
		logic s2_reg;
		logic s3_reg;
		logic filt_reg;

		always_ff @(posedge i_link_clk) begin
			if (lrst_reg) begin
				s1_reg   <= 1'b0;
				s2_reg   <= 1'b0;
				s3_reg   <= 1'b0;
				filt_reg <= 1'b0;
			end else if (ce_l_reg) begin
				s1_reg <= pin_raw[gi];
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
				// received lanes may change every slot; agreement would drop single-slot bits
				if (s2_reg == s3_reg || gi <= LANES) begin
					filt_reg <= s3_reg;
				end
			end
		end

		assign pin_filt[gi] = filt_reg;
	end

	assign tx_sleep_n_f = pin_filt[PIN_W-1];
	assign pix_f        = pin_filt[PIN_W-2];
	assign tx_data_f    = pin_filt[PIN_W-3 -: WORD_W];
	assign rx_sleep_n_f = pin_filt[LANES+1];
	assign clk_lane_f   = pin_filt[LANES];
	assign rx_lanes_f   = pin_filt[LANES-1:0];

	// ================================================================
	// transmitter: capture on the falling pixel clock
	logic              pix_prev_reg;
	logic [WORD_W-1:0] pend_reg;
	logic              tx_run;
	logic              tx_oe_reg;

	// data and strobe share one path; the link clock must outpace hold time
	always_ff @(posedge i_link_clk) begin
		if (lrst_reg) begin
			pix_prev_reg <= 1'b0;
			pend_reg     <= '0;
		end else if (ce_l_reg) begin
			pix_prev_reg <= pix_f;
			if (pix_prev_reg && !pix_f) begin
				pend_reg <= tx_data_f;
			end
		end
	end

	assign tx_run = tx_sleep_n_f & ctrl_l_reg.tx_en;

	always_ff @(posedge i_link_clk) begin
		if (lrst_reg) begin
			tx_oe_reg <= 1'b0;
		end else if (ce_l_reg) begin
			tx_oe_reg <= tx_run;
		end
	end

	assign o_tx_serial_lane_oe = {LANES{tx_oe_reg}};
	assign o_link_clock_out_oe = tx_oe_reg;

	tx_serializer #(
		.LANES (LANES),
		.SLOTS (SLOTS)
	) u_tx (
		.i_clk      (i_link_clk),
		.i_rst      (lrst_reg),
		.i_ce       (ce_l_reg),
		.i_run      (tx_run),
		.i_word     (pend_reg),
		.o_lanes    (o_tx_serial_lane),
		.o_clk_lane (o_link_clock_out)
	);

	// ================================================================
	// receiver: deserialise and regenerate the pixel clock
	rx_word_type      rx_word;
	logic             rx_locked;
	logic             rx_run;
	logic [HW-1:0]    high_cnt_reg;

	rx_deserializer #(
		.LANES (LANES),
		.SLOTS (SLOTS)
	) u_rx (
		.i_clk      (i_link_clk),
		.i_rst      (lrst_reg),
		.i_ce       (ce_l_reg),
		.i_lanes    (rx_lanes_f),
		.i_clk_lane (clk_lane_f),
		.o_word     (rx_word),
		.o_locked   (rx_locked)
	);

	assign rx_run = rx_sleep_n_f & ctrl_l_reg.rx_en;

	// data changes on the rise so it has settled well before the fall
	always_ff @(posedge i_link_clk) begin
		if (lrst_reg) begin
			o_rx_parallel_out <= '0;
			o_pixel_clk_out   <= 1'b0;
			high_cnt_reg      <= '0;
		end else if (ce_l_reg && rx_run) begin
			if (rx_word.valid) begin
				o_rx_parallel_out <= rx_word.data;
				o_pixel_clk_out   <= 1'b1;
				high_cnt_reg      <= HIGH_LAST;
			end else if (o_pixel_clk_out && high_cnt_reg == '0) begin
				o_pixel_clk_out <= 1'b0;
			end else if (o_pixel_clk_out) begin
				high_cnt_reg <= high_cnt_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge i_link_clk) begin
		if (lrst_reg) begin
			stat_link_reg <= '0;
		end else if (ce_l_reg) begin
			stat_link_reg.tx_active <= tx_run;
			stat_link_reg.rx_locked <= rx_locked;
			stat_link_reg.rx_awake  <= rx_run;
		end
	end

	// ================================================================
	// checks
	sequence s_tx_sleep_held;
		$fell(i_tx_sleep_n) ##1 (ce_l_reg && !i_tx_sleep_n) [*3];
	endsequence

	property p_tx_sleep_time;
		@(posedge i_link_clk) disable iff (lrst_reg)
		s_tx_sleep_held |-> ##[0:TX_SLEEP_WAIT] (!o_link_clock_out_oe && o_tx_serial_lane_oe == '0);
	endproperty
	a_tx_sleep_time: assert property (p_tx_sleep_time)
		else $error("transmitter not floated in time after sleep");

	property p_tx_float;
		@(posedge i_link_clk) disable iff (lrst_reg)
		ce_l_reg && !tx_run |=> o_tx_serial_lane_oe == '0 && !o_link_clock_out_oe
			&& o_tx_serial_lane == '0 && !o_link_clock_out;
	endproperty
	a_tx_float: assert property (p_tx_float)
		else $error("transmitter outputs driven while asleep");

	property p_tx_capture;
		@(posedge i_link_clk) disable iff (lrst_reg)
		ce_l_reg && pix_prev_reg && !pix_f |=> pend_reg == $past(tx_data_f);
	endproperty
	a_tx_capture: assert property (p_tx_capture)
		else $error("input word not captured on pixel clock fall");

	property p_rx_freeze;
		@(posedge i_link_clk) disable iff (lrst_reg)
		!rx_run |=> $stable(o_rx_parallel_out) && $stable(o_pixel_clk_out);
	endproperty
	a_rx_freeze: assert property (p_rx_freeze)
		else $error("receiver outputs moved while asleep");

	sequence s_rx_run3;
		(ce_l_reg && rx_run) [*3];
	endsequence

	property p_rx_pixclk_fall;
		@(posedge i_link_clk) disable iff (lrst_reg)
		$rose(o_pixel_clk_out) ##0 s_rx_run3 |=> !o_pixel_clk_out && $stable(o_rx_parallel_out);
	endproperty
	a_rx_pixclk_fall: assert property (p_rx_pixclk_fall)
		else $error("pixel clock fall not three cycles after data");

endmodule

// file: hdl/lvds_link_defs.svh
`ifndef LVDS_LINK_DEFS_SVH
`define LVDS_LINK_DEFS_SVH

// ================================================================
// link geometry
`define PIX_WORD_W          21
`define LINK_LANES          3
`define LINK_SLOTS          7
// clock lane, slot 0 first: low for slots 0..2, high for 3..6
`define CLK_PATTERN         7'h0F

// ================================================================
// register map
`define CTRL_OFS            12'h000
`define STATUS_OFS          12'h004
`define CTRL_TX_EN_BIT      0
`define CTRL_RX_EN_BIT      1
`define CTRL_RST_VAL        2'h3
`define STATUS_TX_ACT_BIT   0
`define STATUS_RX_LOCK_BIT  1
`define STATUS_RX_AWAKE_BIT 2

// ================================================================
// timing
`define LINK_PERIOD_NS      12
`define TX_SLEEP_MAX_NS     100
`define RX_PIXCLK_HIGH_CYC  3

`endif

// file: hdl/lvds_link_pkg.sv
`include "lvds_link_defs.svh"

package lvds_link_pkg;

	typedef struct packed {
		logic rx_en;
		logic tx_en;
	} ctrl_type;

	typedef struct packed {
		logic rx_awake;
		logic rx_locked;
		logic tx_active;
	} status_type;

	typedef struct packed {
		logic                      valid;
		logic [`PIX_WORD_W-1:0]    data;
	} rx_word_type;

endpackage

// file: hdl/rx_deserializer.sv
`timescale 1ns/1ns
`include "lvds_link_defs.svh"

module rx_deserializer
	import lvds_link_pkg::*;
#(
	parameter int LANES = `LINK_LANES,
	parameter int SLOTS = `LINK_SLOTS
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_ce,
	input  wire logic [LANES-1:0] i_lanes,
	input  wire logic             i_clk_lane,
	output rx_word_type           o_word,
	output logic                  o_locked
);

	localparam int            CW   = $clog2(SLOTS + 1);
	localparam logic [CW-1:0] FULL = CW'(SLOTS);
	localparam logic [CW-1:0] LAST = CW'(SLOTS - 1);

	logic                   clk_prev_reg;
	logic [CW-1:0]          cnt_reg;
	logic                   valid_reg;
	logic                   fall;
	logic [LANES*SLOTS-1:0] word_data;

	// a fall of the clock lane marks slot 0 of a new word
	assign fall = clk_prev_reg & ~i_clk_lane;

	// ================================================================
	// framing and lock
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			clk_prev_reg <= 1'b0;
			cnt_reg      <= FULL;
			valid_reg    <= 1'b0;
			o_locked     <= 1'b0;
		end else if (i_ce) begin
			clk_prev_reg <= i_clk_lane;
			valid_reg    <= 1'b0;
			if (fall) begin
				cnt_reg  <= CW'(1);
				// only a fall right after a complete word is a regular one
				o_locked <= valid_reg;
			end else if (cnt_reg != FULL) begin
				cnt_reg <= cnt_reg + 1'b1;
				if (cnt_reg == LAST) begin
					valid_reg <= 1'b1;
				end
			end else begin
				// no fall where one was due: framing lost
				o_locked <= 1'b0;
			end
		end
	end

	// ================================================================
	// per-lane shift in, first slot lands in the top bit
	for (genvar k = 0; k < LANES; k++) begin : g_lane
		logic [SLOTS-1:0] sh_reg;
		logic [SLOTS-1:0] word_reg;

		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				sh_reg   <= '0;
				word_reg <= '0;
			end else if (i_ce) begin
				sh_reg <= {sh_reg[SLOTS-2:0], i_lanes[k]};
				if (!fall && cnt_reg == LAST) begin
					word_reg <= {sh_reg[SLOTS-2:0], i_lanes[k]};
				end
			end
		end

		assign word_data[k*SLOTS +: SLOTS] = word_reg;
	end

	assign o_word.valid = valid_reg;
	assign o_word.data  = word_data;

	// ================================================================
	// checks
	property p_rx_bit_order;
		@(posedge i_clk) disable iff (i_rst)
		i_ce [*8] ##0 o_word.valid |->
			o_word.data[LANES*SLOTS-1] == $past(i_lanes[LANES-1], 7) &&
			o_word.data[0] == $past(i_lanes[0], 1);
	endproperty
	a_rx_bit_order: assert property (p_rx_bit_order)
		else $error("received word bits out of slot order");

	property p_rx_lock_cause;
		@(posedge i_clk) disable iff (i_rst)
		$rose(o_locked) |-> $past(o_word.valid) && $past(fall);
	endproperty
	a_rx_lock_cause: assert property (p_rx_lock_cause)
		else $error("lock without a full seven slot word");

endmodule

// file: hdl/tx_serializer.sv
`timescale 1ns/1ns
`include "lvds_link_defs.svh"

module tx_serializer
	import lvds_link_pkg::*;
#(
	parameter int LANES = `LINK_LANES,
	parameter int SLOTS = `LINK_SLOTS
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_ce,
	input  wire logic                   i_run,
	input  wire logic [LANES*SLOTS-1:0] i_word,
	output logic      [LANES-1:0]       o_lanes,
	output logic                        o_clk_lane
);

	localparam int                SW      = $clog2(SLOTS);
	localparam logic [SW-1:0]     LAST    = SW'(SLOTS - 1);
	localparam logic [SLOTS-1:0]  CLK_PAT = `CLK_PATTERN;

	logic [SW-1:0]          slot_reg;
	logic [SW-1:0]          slot_next;
	logic [LANES*SLOTS-1:0] cur_reg;
	logic [LANES*SLOTS-1:0] word_next;
	logic                   act;

	assign act       = i_ce & i_run;
	assign slot_next = (slot_reg == LAST) ? '0 : slot_reg + 1'b1;
	// a new word is picked up only at the word boundary, after slot 6
	assign word_next = (slot_reg == LAST) ? i_word : cur_reg;

	// ================================================================
	// slot sequencing and clock lane
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			slot_reg   <= LAST;
			cur_reg    <= '0;
			o_clk_lane <= 1'b0;
		end else if (i_ce) begin
			if (!i_run) begin
				slot_reg   <= LAST;
				o_clk_lane <= 1'b0;
			end else begin
				slot_reg   <= slot_next;
				cur_reg    <= word_next;
				o_clk_lane <= CLK_PAT[SLOTS-1-int'(slot_next)];
			end
		end
	end

	// ================================================================
	// data lanes, highest input bit first
	for (genvar k = 0; k < LANES; k++) begin : g_lane
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				o_lanes[k] <= 1'b0;
			end else if (i_ce) begin
				if (!i_run) begin
					o_lanes[k] <= 1'b0;
				end else begin
					o_lanes[k] <= word_next[k*SLOTS+SLOTS-1-int'(slot_next)];
				end
			end
		end

		property p_lane_order;
			@(posedge i_clk) disable iff (i_rst)
			$past(act) |-> o_lanes[k] == cur_reg[k*SLOTS+SLOTS-1-int'(slot_reg)];
		endproperty
		a_lane_order: assert property (p_lane_order)
			else $error("lane bit not in descending slot order");
	end

	// ================================================================
	// checks on the clock lane
	sequence s_clk_fall;
		$fell(o_clk_lane);
	endsequence

	property p_seven_slots;
		@(posedge i_clk) disable iff (i_rst)
		s_clk_fall ##0 act [*7] |=> $fell(o_clk_lane);
	endproperty
	a_seven_slots: assert property (p_seven_slots)
		else $error("link clock period is not seven slots");

	property p_clk_high_slot3;
		@(posedge i_clk) disable iff (i_rst)
		s_clk_fall ##0 act [*3] |=> $rose(o_clk_lane);
	endproperty
	a_clk_high_slot3: assert property (p_clk_high_slot3)
		else $error("link clock did not rise at slot three");

	property p_clk_ref_slot0;
		@(posedge i_clk) disable iff (i_rst)
		s_clk_fall ##0 $past(act) |-> slot_reg == '0;
	endproperty
	a_clk_ref_slot0: assert property (p_clk_ref_slot0)
		else $error("link clock fall not at slot zero");

endmodule

// file: testbench/pixel_source.sv
`timescale 1ns/1ns

// ================================================================
// graphics controller: pixel word source with falling-edge strobe
module pixel_source (
	input  wire logic        i_link_clk,
	input  wire logic        i_run,
	input  wire logic [20:0] i_word,
	output logic      [20:0] o_word,
	output logic             o_pix_clk
);
	logic [2:0] phase_reg;

	initial begin
		phase_reg = 3'h0;
		o_word    = 21'h000000;
		o_pix_clk = 1'h0;
	end

	// seven link cycles a pixel: the fastest rate the serialiser takes
	always @(posedge i_link_clk) begin
		if (!i_run) begin
			phase_reg <= 3'h0;
			o_pix_clk <= 1'h0;
		end else begin
			phase_reg <= (phase_reg == 3'h6) ? 3'h0 : phase_reg + 3'h1;
			o_pix_clk <= (phase_reg < 3'h3);
		end
	end

	// word changes at the rise only, so it is steady across the fall
	always @(posedge i_link_clk) begin
		if (i_run && phase_reg == 3'h0) begin
			o_word <= i_word;
		end
	end
endmodule

// file: testbench/tb_display_lvds_serdes_7to1.sv
`timescale 1ns/1ns
`include "lvds_link_defs.svh"

module tb_display_lvds_serdes_7to1;
	import lvds_link_pkg::*;

	logic        mclk, link_clk, sys_rst, ce, run;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        err;
	logic [20:0] src_word, pix_word, rx_out, w;
	logic        pix_in, tx_sleep_n, rx_sleep_n, clk_out, clk_oe, pix_out;
	logic [2:0]  lane, lane_oe, rx_lane, lane_last;
	logic        clk_last;
	logic [6:0]  cp;
	int          n_mismatch, cmp_count, cyc;
	logic [20:0] tbl [4] = '{21'h155555, 21'h0AAAAA, 21'h100001, 21'h1C0E07};

	always #10 mclk = ~mclk;
	initial begin
		link_clk = 1'h0;
		#2;
		forever #6 link_clk = ~link_clk;
	end

	// ================================================================
	// loopback: released lines show the inverse of their last level
	always @(posedge link_clk) begin
		if (sys_rst) begin
			lane_last <= 3'h0;
			clk_last  <= 1'h0;
		end else begin
			lane_last <= (lane & lane_oe) | (lane_last & ~lane_oe);
			clk_last  <= clk_oe ? clk_out : clk_last;
		end
	end
	assign rx_lane = (lane & lane_oe) | (~lane_last & ~lane_oe);

	display_lvds_serdes_7to1 i_display_lvds_serdes_7to1 (
		.i_mclk(mclk), .i_sys_rst(sys_rst), .i_ce(ce), .i_link_clk(link_clk),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_tx_parallel_in(pix_word), .i_pixel_clk_in(pix_in), .i_tx_sleep_n(tx_sleep_n),
		.o_tx_serial_lane(lane), .o_tx_serial_lane_oe(lane_oe), .o_link_clock_out(clk_out),
		.o_link_clock_out_oe(clk_oe), .i_rx_serial_lane(rx_lane),
		.i_link_clock_in(clk_oe ? clk_out : ~clk_last), .i_rx_sleep_n(rx_sleep_n),
		.o_rx_parallel_out(rx_out), .o_pixel_clk_out(pix_out)
	);

	pixel_source i_pixel_source (
		.i_link_clk(link_clk), .i_run(run), .i_word(src_word), .o_word(pix_word), .o_pix_clk(pix_in)
	);

	// ================================================================
	// tasks
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t register or flag got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp21(input logic [20:0] got, input logic [20:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t pixel word got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
		@(posedge mclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wdata;
		@(posedge mclk);
		penable <= 1'h1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	// waits for the clock-lane fall, then samples seven slots mid-cycle
	task automatic tx_capture();
		int n;
		logic prev;
		n = 0;
		prev = clk_out;
		@(negedge link_clk);
		while (!(prev === 1'h1 && clk_out === 1'h0) && n < 60) begin
			prev = clk_out;
			@(negedge link_clk);
			n++;
		end
		for (int s = 0; s < 7; s++) begin
			if (s > 0) @(negedge link_clk);
			cp[s] = clk_out;
			for (int k = 0; k < 3; k++) w[7*k+6-s] = lane[k];
		end
	endtask

	task automatic pix_fall();
		int n;
		logic prev;
		n = 0;
		prev = pix_out;
		@(negedge link_clk);
		while (!(prev === 1'h1 && pix_out === 1'h0) && n < 60) begin
			prev = pix_out;
			@(negedge link_clk);
			n++;
		end
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 8000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// ================================================================
	// main sequence
	initial begin
		{mclk, sys_rst, ce, run, psel, penable, pwrite} = 7'h30;
		{paddr, pwdata, src_word} = '0;
		{tx_sleep_n, rx_sleep_n} = 2'h3;
		{n_mismatch, cmp_count, cyc} = '0;
		repeat (20) @(posedge mclk);
		sys_rst <= 1'h0;
		run     <= 1'h1;
		apb(1'h0, `CTRL_OFS, 32'h0);
		cmp32(rd, 32'h3);
		apb(1'h0, 12'h008, 32'h0);
		cmp32({rd[30:0], err}, 32'h1);
		apb(1'h1, `CTRL_OFS, 32'h2);
		repeat (10) @(negedge link_clk);
		cmp32({28'h0, clk_oe, lane_oe}, 32'h0);
		apb(1'h1, `CTRL_OFS, 32'h3);
		// lock time allowed before the recovered data is trusted
		rd = '0;
		for (int i = 0; i < 60 && rd[1] !== 1'h1; i++) apb(1'h0, `STATUS_OFS, 32'h0);
		cmp32(rd, 32'h7);
		foreach (tbl[i]) begin
			@(posedge mclk);
			src_word <= tbl[i];
			repeat (24) @(negedge link_clk);
			tx_capture();
			cmp21(w, tbl[i]);
			cmp32({25'h0, cp}, 32'h78);
			cmp32({28'h0, clk_oe, lane_oe}, 32'hF);
			pix_fall();
			pix_fall();
			cmp21(rx_out, tbl[i]);
		end
		@(posedge mclk);
		tx_sleep_n <= 1'h0;
		repeat (9) @(negedge link_clk);
		cmp32({24'h0, clk_oe, lane_oe, clk_out, lane}, 32'h0);
		apb(1'h0, `STATUS_OFS, 32'h0);
		cmp32({31'h0, rd[0]}, 32'h0);
		tx_sleep_n <= 1'h1;
		repeat (30) @(negedge link_clk);
		pix_fall();
		pix_fall();
		cmp21(rx_out, tbl[3]);
		@(posedge link_clk);
		rx_sleep_n <= 1'h0;
		repeat (4) @(posedge link_clk);
		src_word <= 21'h0F0F0F;
		repeat (40) @(negedge link_clk);
		cmp21(rx_out, tbl[3]);
		@(posedge link_clk);
		rx_sleep_n <= 1'h1;
		repeat (10) @(negedge link_clk);
		pix_fall();
		pix_fall();
		cmp21(rx_out, 21'h0F0F0F);
		tally_and_finish();
	end
endmodule
